// ---- design/sspr_pkg.sv ----
// Package: register map, field layout and timing constants for the phase_realign_en block
package sspr_pkg;
   // Printed offsets are not all multiples of four: kept as indices
   localparam int unsigned IDX_TIMING  = 47;
   localparam int unsigned IDX_DETECT  = 48;
   localparam int unsigned IDX_CTRL    = 49;
   localparam int unsigned IDX_STATUS  = 50;
   localparam int unsigned IDX_MASK    = 51;
   localparam int unsigned IDX_STATE   = 52;
   localparam logic [11:0] ADDR_TIMING = 12'(IDX_TIMING * 4);
   localparam logic [11:0] ADDR_DETECT = 12'(IDX_DETECT * 4);
   localparam logic [11:0] ADDR_CTRL   = 12'(IDX_CTRL * 4);
   localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);
   localparam logic [11:0] ADDR_MASK   = 12'(IDX_MASK * 4);
   localparam logic [11:0] ADDR_STATE  = 12'(IDX_STATE * 4);

   localparam logic [7:0] TIMING_RST = 8'h00;
   localparam logic [7:0] DETECT_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Delay step per field unit and clock period
   localparam int unsigned STEP_NS      = 50;
   localparam int unsigned CLK_NS       = 10;
   localparam int unsigned STEP_CYCLES  = (STEP_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic [3:0] phase_realign_en_holdoff_periods;
      logic [3:0] misid_threshold;
   } sspr_timing_t;

   typedef struct packed {
      logic [2:0] ch2_rise_detect_delay;
      logic [2:0] ch2_valley_detect_delay;
      logic       short_protect_disable;
      logic       diff_voltage_fault_disable;
   } sspr_detect_t;

   // Status bits: 0 phase_realign_en done, 1 threshold crossed while held off
   typedef struct packed {
      logic held_off;
      logic phase_realign_en;
   } sspr_irq_t;
endpackage

// ---- design/sspr_delay.sv ----
// Programmable delay of a detector pulse, in steps of a fixed number of cycles
`timescale 1ns/10ps
`default_nettype none
module sspr_delay
   import sspr_pkg::*;
#(
   parameter int unsigned SEL_W = 3,
   parameter int unsigned STEP  = STEP_CYCLES
)(
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic [SEL_W-1:0] sel,
   input  wire logic             det_in,
   output logic                  det_out
);
   localparam int unsigned DEPTH = ((1 << SEL_W) - 1) * STEP + 1;

   // Refused at elaboration: a zero step or width leaves no line to tap
   if (SEL_W < 1 || STEP < 1)
   begin : g_bad_param
      $error("sspr_delay: bad parameters");
   end

   logic [DEPTH-1:0] line_r;

   // Shift line; tap chosen by field, zero gives two register stages
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         line_r <= '0;
      else
         line_r <= {line_r[DEPTH-2:0], det_in};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         det_out <= 1'b0;
      else
         det_out <= line_r[32'(sel) * STEP];
   end
endmodule
`default_nettype wire

// ---- design/sspr_top.sv ----
// Phase phase_realign_en decision, channel-2 detect delays and protection disables, AXI4-Lite registers
// Notes on behaviour
// - Hold-off field bits 7:4, periods between resyncs
// - Threshold field bits 3:0, misidentified periods tolerated
// - Counter plus one wrong, minus two right
// - Phase_realign_en when count exceeds threshold, hold-off elapsed
// - Hold-off and threshold fields act only with phase_realign_en enable set
// - Rising-edge detect delayed field times 50 ns
// - Bit 1 one disables short protection
// - Bit 0 one ignores voltage-difference fault
// - Enable zero means never resynchronize
`timescale 1ns/10ps
`default_nettype none
module sspr_top
   import sspr_pkg::*;
#(
   parameter int unsigned CNT_W = 6
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ch2_period_end,
   input  wire logic        ch2_id_wrong,
   input  wire logic        ch1_period_end,
   input  wire logic        ch2_rise_detect_in,
   input  wire logic        ch2_valley_detect_in,
   input  wire logic        short_fault_in,
   input  wire logic        diff_fault_in,
   output logic             phase_phase_realign_en,
   output logic             ch2_rise_detect_out,
   output logic             ch2_valley_detect_out,
   output logic             short_fault_out,
   output logic             diff_fault_out,
   output logic             irq
);
   // Count must pass the largest threshold and still fit the state byte
   if (CNT_W < 5 || CNT_W > 8)
   begin : g_bad_param
      $error("sspr_top: counter width out of range");
   end

   function automatic logic [7:0] idx_of(input logic [11:0] a);
      idx_of = a[9:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   sspr_timing_t timing_r;
   sspr_detect_t detect_r;
   logic         phase_realign_en_r;
   sspr_irq_t    status_r;
   sspr_irq_t    mask_r;
   logic [CNT_W-1:0] misid_cnt_r;
   logic [3:0]   holdoff_cnt_r;
   logic         aw_got_r;
   logic         w_got_r;
   logic [11:0]  awaddr_r;
   logic [31:0]  wdata_r;
   logic [3:0]   wstrb_r;
   logic         do_write;
   logic         wr_ok;
   logic         rd_ok;
   logic [31:0]  rd_val;
   logic         fire;
   logic         blocked;

   ////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_got_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_got_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_r      <= 1'b1;
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_r      <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write)
         begin
            aw_got_r     <= 1'b0;
            w_got_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_comb
   begin
      case (idx_of(awaddr_r))
         8'(IDX_TIMING), 8'(IDX_DETECT), 8'(IDX_CTRL),
         8'(IDX_STATUS), 8'(IDX_MASK), 8'(IDX_STATE): wr_ok = (awaddr_r[11:10] == 2'h0);
         default: wr_ok = 1'b0;
      endcase
   end

   // Configuration registers; only the low byte lane carries data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timing_r           <= TIMING_RST;
         detect_r           <= DETECT_RST;
         phase_realign_en_r <= 1'b0;
         mask_r             <= '0;
      end
      else if (do_write && wr_ok && wstrb_r[0])
      begin
         case (idx_of(awaddr_r))
            8'(IDX_TIMING): timing_r <= wdata_r[7:0];
            8'(IDX_DETECT): detect_r <= wdata_r[7:0];
            8'(IDX_CTRL):   phase_realign_en_r <= wdata_r[0];
            8'(IDX_MASK):   mask_r <= wdata_r[1:0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read channel
   always_comb
   begin
      rd_ok  = (s_axi_araddr[11:10] == 2'h0);
      rd_val = 32'h0000_0000;
      case (idx_of(s_axi_araddr))
         8'(IDX_TIMING): rd_val[7:0] = timing_r;
         8'(IDX_DETECT): rd_val[7:0] = detect_r;
         8'(IDX_CTRL):   rd_val[0]   = phase_realign_en_r;
         8'(IDX_STATUS): rd_val[1:0] = status_r;
         8'(IDX_MASK):   rd_val[1:0] = mask_r;
         8'(IDX_STATE):  rd_val[15:0] = {4'h0, holdoff_cnt_r, 8'(misid_cnt_r)};
         default:        rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_ok ? rd_val : 32'h0000_0000;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase_realign_en decision
   assign blocked = (holdoff_cnt_r != 4'h0);
   assign fire = phase_realign_en_r
                 && (32'(misid_cnt_r) > 32'(timing_r.misid_threshold))
                 && !blocked;

   // Counter: +1 on wrong, -2 on right, floor at zero, cleared by phase_realign_en
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         misid_cnt_r <= '0;
      else if (fire || !phase_realign_en_r)
         misid_cnt_r <= '0;
      else if (ch2_period_end)
      begin
         if (ch2_id_wrong)
         begin
            if (misid_cnt_r != '1)
               misid_cnt_r <= misid_cnt_r + 1'b1;
         end
         else if (misid_cnt_r >= CNT_W'(2))
            misid_cnt_r <= misid_cnt_r - CNT_W'(2);
         else
            misid_cnt_r <= '0;
      end
   end

   // Hold-off counts channel-1 periods since the last phase_realign_en
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         holdoff_cnt_r <= 4'h0;
      else if (fire)
         holdoff_cnt_r <= timing_r.phase_realign_en_holdoff_periods;
      else if (ch1_period_end && blocked)
         holdoff_cnt_r <= holdoff_cnt_r - 4'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         phase_phase_realign_en <= 1'b0;
      else
         phase_phase_realign_en <= fire;
   end

   ////////////////////////////////////////////////////////////////////////
   // Events: set wins over write-one-to-clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_r <= '0;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (do_write && wr_ok && wstrb_r[0] && idx_of(awaddr_r) == 8'(IDX_STATUS) && wdata_r[i])
               status_r[i] <= 1'b0;
         end
         if (fire)
            status_r.phase_realign_en <= 1'b1;
         if (phase_realign_en_r && blocked
             && 32'(misid_cnt_r) > 32'(timing_r.misid_threshold))
            status_r.held_off <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(status_r & mask_r);
   end

   ////////////////////////////////////////////////////////////////////////
   // Detector delays; one extra stage keeps outputs registered
   sspr_delay #(.SEL_W(3), .STEP(STEP_CYCLES)) u_rise
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sel     (detect_r.ch2_rise_detect_delay),
      .det_in  (ch2_rise_detect_in),
      .det_out (ch2_rise_detect_out)
   );

   sspr_delay #(.SEL_W(3), .STEP(STEP_CYCLES)) u_valley
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sel     (detect_r.ch2_valley_detect_delay),
      .det_in  (ch2_valley_detect_in),
      .det_out (ch2_valley_detect_out)
   );

   // Fault gating toward the protection module
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         short_fault_out <= 1'b0;
         diff_fault_out  <= 1'b0;
      end
      else
      begin
         short_fault_out <= short_fault_in && !detect_r.short_protect_disable;
         diff_fault_out  <= diff_fault_in && !detect_r.diff_voltage_fault_disable;
      end
   end
endmodule
`default_nettype wire

// ---- sim/sspr_top_props.sv ----
// Checker: port-level properties of the phase_realign_en block
`timescale 1ns/10ps
`default_nettype none
module sspr_top_props
   import sspr_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        ch1_period_end,
   input wire logic        ch2_period_end,
   input wire logic        short_fault_in,
   input wire logic        short_fault_out,
   input wire logic        diff_fault_in,
   input wire logic        diff_fault_out,
   input wire logic        phase_phase_realign_en
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////
   a_short_gate:
   assert property (short_fault_out |-> $past(short_fault_in)) else $error("short fault out without input");
   a_diff_gate:
   assert property (diff_fault_out |-> $past(diff_fault_in)) else $error("diff fault out without input");
   a_phase_realign_en_single:
   assert property (phase_phase_realign_en |=> !phase_phase_realign_en) else $error("phase_realign_en pulse too long");
   // A write may lower the threshold, so a register update is a cause too
   a_phase_realign_en_cause:
   assert property (phase_phase_realign_en |-> $past(ch2_period_end, 2) || $past(ch1_period_end, 2) || $past(s_axi_bvalid))
      else $error("phase_realign_en without cause");
   a_bresp_hold:
   assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_hold:
   assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
      else $error("read data dropped");
   a_slverr_zero:
   assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
      else $error("error read with data");
   a_read_answer:
   assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
endmodule
bind sspr_top sspr_top_props u_props (.*);
`default_nettype wire

// ---- sim/sspr_top_tb.sv ----
// Testbench: registers, fault gates, detect delays and phase_realign_en decisions
`timescale 1ns/10ps
`default_nettype none
module sspr_top_tb;
   import sspr_pkg::*;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        ch2_period_end, ch2_id_wrong, ch1_period_end, ch2_rise_detect_in, ch2_valley_detect_in;
   logic        short_fault_in, diff_fault_in, phase_phase_realign_en, ch2_rise_detect_out, ch2_valley_detect_out;
   logic        short_fault_out, diff_fault_out;
   int          mismatches, checks, rs, d1, d2;
   logic [33:0] rq[$];
   logic [1:0]  bq[$];

   sspr_top dut (.*);

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      bq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid || s_axi_wvalid);
      // Late ready on purpose, so the response has to stand
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [33:0] e);
      rq.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   // One period pulse of either channel, then time for the decision
   task automatic pls(input logic c1, input logic w);
      ch1_period_end <= c1;
      ch2_period_end <= !c1;
      ch2_id_wrong <= w;
      @(posedge aclk);
      ch1_period_end <= 1'b0;
      ch2_period_end <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////
   always @(posedge aclk)
   begin
      if (s_axi_rvalid && s_axi_rready)
         chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready)
         chk(s_axi_bresp, bq.pop_front());
      if (phase_phase_realign_en === 1'b1)
         rs++;
   end

   initial
   begin
      repeat (10000) @(posedge aclk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {ch2_period_end, ch2_id_wrong, ch1_period_end, ch2_rise_detect_in, ch2_valley_detect_in} = '0;
      {short_fault_in, diff_fault_in, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      seed = 32'h43;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(ADDR_TIMING, {RESP_OKAY, 32'h0});
      rd(ADDR_DETECT, {RESP_OKAY, 32'h0});
      for (int i = 0; i < 4; i++)
      begin
         seed = xs(seed);
         wr(i[0] ? ADDR_DETECT : ADDR_TIMING, seed[7:0], RESP_OKAY);
         rd(i[0] ? ADDR_DETECT : ADDR_TIMING, {RESP_OKAY, 24'h0, seed[7:0]});
      end
      wr(12'h000, 8'h5A, RESP_SLVERR);
      rd(12'h000, {RESP_SLVERR, 32'h0});
      for (int v = 0; v < 4; v++)
      begin
         wr(ADDR_DETECT, 8'(v), RESP_OKAY);
         short_fault_in <= 1'b1;
         diff_fault_in <= 1'b1;
         repeat (3) @(posedge aclk);
         chk(short_fault_out, !v[1]);
         chk(diff_fault_out, !v[0]);
         short_fault_in <= 1'b0;
         diff_fault_in <= 1'b0;
      end
      for (int f = 0; f < 8; f++)
      begin
         wr(ADDR_DETECT, 8'((f << 5) | ((7 - f) << 2)), RESP_OKAY);
         ch2_rise_detect_in <= 1'b1;
         ch2_valley_detect_in <= 1'b1;
         @(posedge aclk);
         ch2_rise_detect_in <= 1'b0;
         ch2_valley_detect_in <= 1'b0;
         d1 = 0;
         d2 = 0;
         for (int n = 1; n < 45; n++)
         begin
            @(posedge aclk);
            if (ch2_rise_detect_out === 1'b1 && d1 == 0)
               d1 = n;
            if (ch2_valley_detect_out === 1'b1 && d2 == 0)
               d2 = n;
         end
         chk(d1, 2 + STEP_CYCLES * f);
         chk(d2, 2 + STEP_CYCLES * (7 - f));
      end
      wr(ADDR_TIMING, 8'h00, RESP_OKAY);
      pls(1'b0, 1'b1);
      pls(1'b0, 1'b1);
      chk(rs, 0);
      wr(ADDR_CTRL, 8'h01, RESP_OKAY);
      wr(ADDR_MASK, 8'h01, RESP_OKAY);
      pls(1'b0, 1'b1);
      chk(rs, 1);
      chk(irq, 1'b1);
      rd(ADDR_STATUS, {RESP_OKAY, 32'h1});
      wr(ADDR_STATUS, 8'h01, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(irq, 1'b0);
      // Dips to zero and climbs by one: early firing means wrong steps
      wr(ADDR_TIMING, 8'h02, RESP_OKAY);
      for (int i = 0; i < 7; i++)
      begin
         pls(1'b0, 1'(7'h76 >> i));
         chk(rs, 1 + (i == 6));
      end
      wr(ADDR_TIMING, 8'h20, RESP_OKAY);
      pls(1'b0, 1'b1);
      chk(rs, 3);
      pls(1'b0, 1'b1);
      chk(rs, 3);
      pls(1'b1, 1'b0);
      chk(rs, 3);
      pls(1'b1, 1'b0);
      chk(rs, 4);
      rd(ADDR_STATUS, {RESP_OKAY, 32'h3});
      finish_test();
   end
endmodule
`default_nettype wire
